// *** spcr_consts.svh ***
// register offsets, field positions, reset values and byte counts for the port control bank
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH

// printed offsets are register indices; byte address is four times the index
`define SPCR_IDX_CTRL_B 8'h02
`define SPCR_IDX_TAG 8'h04
`define SPCR_IDX_RATE 8'h06
`define SPCR_ADDR_CTRL_B 12'h008
`define SPCR_ADDR_TAG 12'h010
`define SPCR_ADDR_RATE 12'h018

`define SPCR_B_VLAN_FILT 14
`define SPCR_B_NONDEF_DISC 13
`define SPCR_B_FORCE_FC 12
`define SPCR_B_BACKPR 11
`define SPCR_B_TX_EN 10
`define SPCR_B_RX_EN 9
`define SPCR_B_LEARN_DIS 8
`define SPCR_B_MIRROR_DST 7
`define SPCR_B_RX_MIRROR 6
`define SPCR_B_TX_MIRROR 5
`define SPCR_B_PRI_CEIL 3
`define SPCR_F_MEMBER_HI 2
`define SPCR_F_MEMBER_LO 0
`define SPCR_F_UPRI_HI 15
`define SPCR_F_UPRI_LO 13
`define SPCR_B_CFI 12
`define SPCR_F_VID_HI 11
`define SPCR_F_VID_LO 0
`define SPCR_F_LMODE_HI 3
`define SPCR_F_LMODE_LO 2
`define SPCR_B_CNT_IFG 1
`define SPCR_B_CNT_PRE 0

`define SPCR_RST_CTRL_B 16'h0607
`define SPCR_RST_TAG 16'h0001
`define SPCR_RST_RATE 16'h0000
`define SPCR_WMASK_CTRL_B 16'h7FEF
`define SPCR_WMASK_TAG 16'hFFFF
`define SPCR_WMASK_RATE 16'h000F

`define SPCR_IFG_BYTES 5'h0C
`define SPCR_PRE_BYTES 5'h08
`define SPCR_NULL_VID 12'h000

`endif

// *** spcr_pkg.sv ***
// types shared by the port control register bank
package spcr_pkg;
  typedef enum logic [1:0] {
    SPCR_LIM_ALL = 2'h0,
    SPCR_LIM_BMF = 2'h1,
    SPCR_LIM_BM = 2'h2,
    SPCR_LIM_B = 2'h3
  } spcr_limit_e;
  typedef logic [15:0] spcr_reg_t;
endpackage

// *** spcr_port_ctrl.sv ***
// port one control registers with ingress/egress frame policy
`timescale 1ns/1ps
`include "spcr_consts.svh"

module spcr_port_ctrl #(
  parameter int LEN_W = 11
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // resolved flow-control outcome from auto-negotiation
  input wire logic an_pause,
  // ingress frame descriptor
  input wire logic rx_frm_valid,
  input wire logic [2:0] rx_frm_member,
  input wire logic rx_frm_tagged,
  input wire logic [11:0] rx_frm_vid,
  input wire logic [2:0] rx_frm_pri,
  input wire logic rx_frm_cfi,
  input wire logic rx_frm_bcast,
  input wire logic rx_frm_mcast,
  input wire logic rx_frm_flood,
  input wire logic [LEN_W-1:0] rx_frm_len,
  // egress frame descriptor
  input wire logic tx_frm_valid,
  input wire logic tx_frm_untagged,
  input wire logic [LEN_W-1:0] tx_frm_len,
  // ingress decision
  output logic rx_res_valid,
  output logic rx_res_drop,
  output logic [11:0] rx_res_vid,
  output logic [2:0] rx_res_pri,
  output logic rx_res_cfi,
  output logic rx_res_learn,
  output logic rx_res_monitor,
  output logic rx_res_rate_count,
  output logic [LEN_W+1:0] rx_res_rate_bytes,
  // egress decision
  output logic tx_res_valid,
  output logic tx_res_monitor,
  output logic tx_res_insert,
  output logic [15:0] tx_res_tag,
  output logic [LEN_W+1:0] tx_res_rate_bytes,
  // port level controls
  output logic port_fc_en,
  output logic port_backpr_en,
  output logic port_tx_en,
  output logic port_rx_en,
  output logic port_mirror_dst,
  output logic [2:0] port_member
);

  spcr_pkg::spcr_reg_t ctrl_b_reg;
  spcr_pkg::spcr_reg_t tag_reg;
  spcr_pkg::spcr_reg_t rate_reg;
  spcr_pkg::spcr_reg_t ctrl_b_next;
  spcr_pkg::spcr_reg_t tag_next;
  spcr_pkg::spcr_reg_t rate_next;

  // ---------------- apb decode ----------------
  wire logic setup_ph = psel & ~penable & ~pready;
  wire logic wr_take = psel & penable & pready & pwrite;
  wire logic hit_b = (paddr == `SPCR_ADDR_CTRL_B);
  wire logic hit_tag = (paddr == `SPCR_ADDR_TAG);
  wire logic hit_rate = (paddr == `SPCR_ADDR_RATE);
  wire logic hit_any = hit_b | hit_tag | hit_rate;
  wire logic [15:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // reserved bits are masked on both read and write paths
  wire logic [15:0] rd_word =
    hit_b ? (ctrl_b_reg & `SPCR_WMASK_CTRL_B) :
    hit_tag ? (tag_reg & `SPCR_WMASK_TAG) :
    hit_rate ? (rate_reg & `SPCR_WMASK_RATE) : 16'h0000;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask,
                                        input logic [15:0] lanes, input logic [15:0] data);
    logic [15:0] m;
    m = wmask & lanes;
    merge = (old & ~m) | (data & m);
  endfunction

  assign ctrl_b_next = (wr_take & hit_b) ?
    merge(ctrl_b_reg, `SPCR_WMASK_CTRL_B, lane_mask, pwdata[15:0]) : ctrl_b_reg;
  assign tag_next = (wr_take & hit_tag) ?
    merge(tag_reg, `SPCR_WMASK_TAG, lane_mask, pwdata[15:0]) : tag_reg;
  assign rate_next = (wr_take & hit_rate) ?
    merge(rate_reg, `SPCR_WMASK_RATE, lane_mask, pwdata[15:0]) : rate_reg;

  // no wait state: answer is prepared in setup, presented in the first access cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~hit_any;
      prdata <= (setup_ph & ~pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_b_reg <= `SPCR_RST_CTRL_B;
      tag_reg <= `SPCR_RST_TAG;
      rate_reg <= `SPCR_RST_RATE;
    end else if (ce) begin
      ctrl_b_reg <= ctrl_b_next;
      tag_reg <= tag_next;
      rate_reg <= rate_next;
    end
  end

  // ---------------- field views ----------------
  wire logic vlan_filt = ctrl_b_reg[`SPCR_B_VLAN_FILT];
  wire logic nondef_disc = ctrl_b_reg[`SPCR_B_NONDEF_DISC];
  wire logic force_fc = ctrl_b_reg[`SPCR_B_FORCE_FC];
  wire logic tx_en = ctrl_b_reg[`SPCR_B_TX_EN];
  wire logic rx_en = ctrl_b_reg[`SPCR_B_RX_EN];
  wire logic learn_dis = ctrl_b_reg[`SPCR_B_LEARN_DIS];
  wire logic rx_mirror = ctrl_b_reg[`SPCR_B_RX_MIRROR];
  wire logic tx_mirror = ctrl_b_reg[`SPCR_B_TX_MIRROR];
  wire logic pri_ceil = ctrl_b_reg[`SPCR_B_PRI_CEIL];
  wire logic [2:0] def_pri = tag_reg[`SPCR_F_UPRI_HI:`SPCR_F_UPRI_LO];
  wire logic def_cfi = tag_reg[`SPCR_B_CFI];
  wire logic [11:0] def_vid = tag_reg[`SPCR_F_VID_HI:`SPCR_F_VID_LO];
  spcr_pkg::spcr_limit_e lmode;
  assign lmode = spcr_pkg::spcr_limit_e'(rate_reg[`SPCR_F_LMODE_HI:`SPCR_F_LMODE_LO]);
  wire logic cnt_ifg = rate_reg[`SPCR_B_CNT_IFG];
  wire logic cnt_pre = rate_reg[`SPCR_B_CNT_PRE];

  // ---------------- ingress policy ----------------
  // bit 0 of the vlan table membership stands for this port
  wire logic filt_drop = vlan_filt & ~rx_frm_member[0];
  wire logic use_def_vid = ~rx_frm_tagged | (rx_frm_vid == `SPCR_NULL_VID);
  wire logic [11:0] eff_vid = use_def_vid ? def_vid : rx_frm_vid;
  // null-vid tagged frames take the default vid, so they never count as mismatched
  wire logic vid_drop = nondef_disc & (eff_vid != def_vid);
  wire logic rx_drop = ~rx_en | filt_drop | vid_drop;
  wire logic [2:0] tag_pri = (pri_ceil & (rx_frm_pri > def_pri)) ? def_pri : rx_frm_pri;
  wire logic [2:0] eff_pri = rx_frm_tagged ? tag_pri : def_pri;
  wire logic eff_cfi = rx_frm_tagged ? rx_frm_cfi : def_cfi;

  logic class_hit;
  always_comb begin
    case (lmode)
      spcr_pkg::SPCR_LIM_ALL: class_hit = 1'b1;
      spcr_pkg::SPCR_LIM_BMF: class_hit = rx_frm_bcast | rx_frm_mcast | rx_frm_flood;
      spcr_pkg::SPCR_LIM_BM: class_hit = rx_frm_bcast | rx_frm_mcast;
      spcr_pkg::SPCR_LIM_B: class_hit = rx_frm_bcast;
      default: class_hit = 1'b1;
    endcase
  end

  // overhead bytes shared by ingress and egress accounting
  wire logic [4:0] ovh_bytes =
    (cnt_ifg ? `SPCR_IFG_BYTES : 5'h00) + (cnt_pre ? `SPCR_PRE_BYTES : 5'h00);
  wire logic [LEN_W+1:0] rx_bytes = (LEN_W+2)'(rx_frm_len) + (LEN_W+2)'(ovh_bytes);
  wire logic [LEN_W+1:0] tx_bytes = (LEN_W+2)'(tx_frm_len) + (LEN_W+2)'(ovh_bytes);

  wire logic rx_acc = rx_frm_valid & ~rx_drop;
  wire logic tx_acc = tx_frm_valid & tx_en;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_res_valid <= 1'b0;
      rx_res_drop <= 1'b0;
      rx_res_vid <= 12'h000;
      rx_res_pri <= 3'h0;
      rx_res_cfi <= 1'b0;
      rx_res_learn <= 1'b0;
      rx_res_monitor <= 1'b0;
      rx_res_rate_count <= 1'b0;
      rx_res_rate_bytes <= '0;
    end else if (ce) begin
      rx_res_valid <= rx_frm_valid;
      rx_res_drop <= rx_frm_valid & rx_drop;
      rx_res_vid <= eff_vid;
      rx_res_pri <= eff_pri;
      rx_res_cfi <= eff_cfi;
      rx_res_learn <= rx_acc & ~learn_dis;
      rx_res_monitor <= rx_acc & rx_mirror;
      rx_res_rate_count <= rx_acc & class_hit;
      rx_res_rate_bytes <= rx_bytes;
    end
  end

  // ---------------- egress policy ----------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_res_valid <= 1'b0;
      tx_res_monitor <= 1'b0;
      tx_res_insert <= 1'b0;
      tx_res_tag <= 16'h0000;
      tx_res_rate_bytes <= '0;
    end else if (ce) begin
      tx_res_valid <= tx_acc;
      tx_res_monitor <= tx_acc & tx_mirror;
      tx_res_insert <= tx_acc & tx_frm_untagged;
      tx_res_tag <= tag_reg;
      tx_res_rate_bytes <= tx_bytes;
    end
  end

  // ---------------- port controls ----------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      port_fc_en <= 1'b0;
      port_backpr_en <= 1'b0;
      port_tx_en <= 1'b0;
      port_rx_en <= 1'b0;
      port_mirror_dst <= 1'b0;
      port_member <= 3'h0;
    end else if (ce) begin
      port_fc_en <= force_fc | an_pause;
      port_backpr_en <= ctrl_b_reg[`SPCR_B_BACKPR];
      port_tx_en <= tx_en;
      port_rx_en <= rx_en;
      port_mirror_dst <= ctrl_b_reg[`SPCR_B_MIRROR_DST];
      port_member <= ctrl_b_reg[`SPCR_F_MEMBER_HI:`SPCR_F_MEMBER_LO];
    end
  end

  // ---------------- assertions ----------------
  property p_filter_drop;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && vlan_filt && !rx_frm_member[0] |=> rx_res_valid && rx_res_drop;
  endproperty
  a_filter_drop: assert property (p_filter_drop) else $error("filtered frame not dropped");

  property p_nondef_drop;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && nondef_disc && rx_frm_tagged && rx_frm_vid != 12'h000
      && rx_frm_vid != def_vid |=> rx_res_drop;
  endproperty
  a_nondef_drop: assert property (p_nondef_drop) else $error("non-default vid kept");

  property p_force_fc;
    @(posedge mclk) disable iff (rst)
    ce && force_fc |=> port_fc_en;
  endproperty
  a_force_fc: assert property (p_force_fc) else $error("forced flow control not on");

  property p_tx_block;
    @(posedge mclk) disable iff (rst)
    ce && !tx_en |=> !tx_res_valid && !tx_res_insert;
  endproperty
  a_tx_block: assert property (p_tx_block) else $error("frame sent while disabled");

  property p_rx_block;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && !rx_en |=> rx_res_drop && !rx_res_learn && !rx_res_monitor;
  endproperty
  a_rx_block: assert property (p_rx_block) else $error("frame accepted while disabled");

  property p_no_learn;
    @(posedge mclk) disable iff (rst)
    ce && learn_dis |=> !rx_res_learn;
  endproperty
  a_no_learn: assert property (p_no_learn) else $error("learning while disabled");

  property p_ceiling;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && rx_frm_tagged && pri_ceil |=> rx_res_pri <= $past(def_pri);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("priority above ceiling");

  property p_default_vid;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && !rx_frm_tagged |=> rx_res_vid == $past(def_vid);
  endproperty
  a_default_vid: assert property (p_default_vid) else $error("untagged vid wrong");

  property p_bcast_only;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && lmode == spcr_pkg::SPCR_LIM_B && !rx_frm_bcast
      |=> !rx_res_rate_count;
  endproperty
  a_bcast_only: assert property (p_bcast_only) else $error("non-broadcast counted");

  property p_overhead;
    @(posedge mclk) disable iff (rst)
    ce && cnt_ifg && cnt_pre |=> rx_res_rate_bytes == $past(rx_frm_len) + 20;
  endproperty
  a_overhead: assert property (p_overhead) else $error("overhead bytes wrong");

  property p_reserved;
    @(posedge mclk) disable iff (rst)
    pready && !pslverr && psel && !pwrite && paddr == `SPCR_ADDR_RATE
      |-> prdata[31:4] == 28'h0000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_insert_tag;
    @(posedge mclk) disable iff (rst)
    ce && tx_frm_valid && tx_en && tx_frm_untagged |=> tx_res_insert
      && tx_res_tag[11:0] == $past(def_vid);
  endproperty
  a_insert_tag: assert property (p_insert_tag) else $error("inserted tag vid wrong");

  property p_backpr;
    @(posedge mclk) disable iff (rst)
    ce |=> port_backpr_en == $past(ctrl_b_reg[`SPCR_B_BACKPR]);
  endproperty
  a_backpr: assert property (p_backpr) else $error("back pressure enable wrong");

  property p_port_en;
    @(posedge mclk) disable iff (rst)
    ce |=> port_tx_en == $past(tx_en) && port_rx_en == $past(rx_en);
  endproperty
  a_port_en: assert property (p_port_en) else $error("port enable wrong");

  property p_mirror_dst;
    @(posedge mclk) disable iff (rst)
    ce |=> port_mirror_dst == $past(ctrl_b_reg[`SPCR_B_MIRROR_DST]);
  endproperty
  a_mirror_dst: assert property (p_mirror_dst) else $error("monitor port flag wrong");

  property p_rx_monitor;
    @(posedge mclk) disable iff (rst)
    ce && rx_mirror |=> rx_res_monitor == (rx_res_valid && !rx_res_drop);
  endproperty
  a_rx_monitor: assert property (p_rx_monitor) else $error("rx monitor mark wrong");

  property p_tx_monitor;
    @(posedge mclk) disable iff (rst)
    ce && tx_mirror |=> tx_res_monitor == tx_res_valid;
  endproperty
  a_tx_monitor: assert property (p_tx_monitor) else $error("tx monitor mark wrong");

  property p_member;
    @(posedge mclk) disable iff (rst)
    ce |=> port_member == $past(ctrl_b_reg[`SPCR_F_MEMBER_HI:`SPCR_F_MEMBER_LO]);
  endproperty
  a_member: assert property (p_member) else $error("membership mask wrong");

  property p_untag_default;
    @(posedge mclk) disable iff (rst)
    ce && rx_frm_valid && !rx_frm_tagged |=> rx_res_pri == $past(def_pri)
      && rx_res_cfi == $past(def_cfi);
  endproperty
  a_untag_default: assert property (p_untag_default) else $error("untagged pri wrong");

  property p_preamble;
    @(posedge mclk) disable iff (rst)
    ce && cnt_pre && !cnt_ifg |=> tx_res_rate_bytes == $past(tx_frm_len) + 8;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble bytes wrong");

endmodule

// *** spcr_port_ctrl_tb.sv ***
// self-checking testbench for the port one control register bank
`timescale 1ns/1ps
`include "spcr_consts.svh"

module testbench;
  localparam int LW = 11;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, an_pause = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic rx_frm_valid = 1'b0, rx_frm_tagged = 1'b0, rx_frm_cfi = 1'b0;
  logic rx_frm_bcast = 1'b0, rx_frm_mcast = 1'b0, rx_frm_flood = 1'b0;
  logic [2:0] rx_frm_member = 3'h0, rx_frm_pri = 3'h0;
  logic [11:0] rx_frm_vid = 12'h000;
  logic [LW-1:0] rx_frm_len = '0, tx_frm_len = '0;
  logic tx_frm_valid = 1'b0, tx_frm_untagged = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_res_valid, rx_res_drop, rx_res_cfi, rx_res_learn, rx_res_monitor;
  logic rx_res_rate_count, tx_res_valid, tx_res_monitor, tx_res_insert;
  logic port_fc_en, port_backpr_en, port_tx_en, port_rx_en, port_mirror_dst;
  logic [11:0] rx_res_vid;
  logic [2:0] rx_res_pri, port_member;
  logic [LW+1:0] rx_res_rate_bytes, tx_res_rate_bytes;
  logic [15:0] tx_res_tag;
  // shadows follow the documented reset values and writable fields
  logic [15:0] sh_ctl = 16'h0607, sh_tag = 16'h0001, sh_rat = 16'h0000;
  int n_errors = 0;
  int cmp_count = 0;

  always #2.5 mclk = ~mclk;

  spcr_port_ctrl #(.LEN_W(LW)) u_dut (
    .mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .an_pause, .rx_frm_valid, .rx_frm_member, .rx_frm_tagged, .rx_frm_vid,
    .rx_frm_pri, .rx_frm_cfi, .rx_frm_bcast, .rx_frm_mcast, .rx_frm_flood, .rx_frm_len,
    .tx_frm_valid, .tx_frm_untagged, .tx_frm_len, .rx_res_valid, .rx_res_drop, .rx_res_vid,
    .rx_res_pri, .rx_res_cfi, .rx_res_learn, .rx_res_monitor, .rx_res_rate_count,
    .rx_res_rate_bytes, .tx_res_valid, .tx_res_monitor, .tx_res_insert, .tx_res_tag,
    .tx_res_rate_bytes, .port_fc_en, .port_backpr_en, .port_tx_en, .port_rx_en,
    .port_mirror_dst, .port_member
  );

  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge; data and error taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, {16'h0000, v}, rd, e);
    check(32'(e), 32'h0);
    if (a == `SPCR_ADDR_CTRL_B) sh_ctl = v & 16'h7FEF;
    if (a == `SPCR_ADDR_TAG) sh_tag = v;
    if (a == `SPCR_ADDR_RATE) sh_rat = v & 16'h000F;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h00000000, rd, e);
    check(rd, exp);
    check(32'(e), 32'(experr));
  endtask

  function automatic logic [LW+1:0] rbytes(input logic [LW-1:0] len);
    return {2'b00, len} + (sh_rat[1] ? 13'h00C : 13'h000) + (sh_rat[0] ? 13'h008 : 13'h000);
  endfunction

  task automatic port_chk;
    @(posedge mclk);
    @(negedge mclk);
    check(32'(port_fc_en), 32'(sh_ctl[12] | an_pause));
    check(32'(port_backpr_en), 32'(sh_ctl[11]));
    check(32'(port_tx_en), 32'(sh_ctl[10]));
    check(32'(port_rx_en), 32'(sh_ctl[9]));
    check(32'(port_mirror_dst), 32'(sh_ctl[7]));
    check(32'(port_member), 32'(sh_ctl[2:0]));
  endtask

  task automatic rx_chk(input logic tg, input logic [11:0] v, input logic [2:0] p,
                        input logic [2:0] m, input logic [2:0] cls3, input logic [LW-1:0] len);
    logic [11:0] ev;
    logic [2:0] ep;
    logic drop, cls;
    ev = (!tg || v == 12'h000) ? sh_tag[11:0] : v;
    ep = !tg ? sh_tag[15:13] : (sh_ctl[3] && p > sh_tag[15:13]) ? sh_tag[15:13] : p;
    drop = !sh_ctl[9] || (sh_ctl[14] && !m[0]) || (sh_ctl[13] && ev != sh_tag[11:0]);
    case (sh_rat[3:2])
      2'h0: cls = 1'b1;
      2'h1: cls = |cls3;
      2'h2: cls = cls3[2] | cls3[1];
      default: cls = cls3[2];
    endcase
    @(posedge mclk);
    rx_frm_valid <= 1'b1;
    rx_frm_tagged <= tg;
    rx_frm_cfi <= tg;
    rx_frm_vid <= v;
    rx_frm_pri <= p;
    rx_frm_member <= m;
    {rx_frm_bcast, rx_frm_mcast, rx_frm_flood} <= cls3;
    rx_frm_len <= len;
    @(posedge mclk);
    rx_frm_valid <= 1'b0;
    @(negedge mclk);
    check(32'(rx_res_valid), 32'h1);
    check(32'(rx_res_drop), 32'(drop));
    check(32'(rx_res_learn), 32'(!drop && !sh_ctl[8]));
    check(32'(rx_res_monitor), 32'(!drop && sh_ctl[6]));
    check(32'(rx_res_rate_count), 32'(!drop && cls));
    if (!drop) begin
      check(32'(rx_res_vid), 32'(ev));
      check(32'(rx_res_pri), 32'(ep));
      check(32'(rx_res_cfi), 32'(tg ? 1'b1 : sh_tag[12]));
      check(32'(rx_res_rate_bytes), 32'(rbytes(len)));
    end
  endtask

  task automatic tx_chk(input logic un, input logic [LW-1:0] len);
    @(posedge mclk);
    tx_frm_valid <= 1'b1;
    tx_frm_untagged <= un;
    tx_frm_len <= len;
    @(posedge mclk);
    tx_frm_valid <= 1'b0;
    @(negedge mclk);
    check(32'(tx_res_valid), 32'(sh_ctl[10]));
    check(32'(tx_res_tag), 32'(sh_tag));
    check(32'(tx_res_monitor), 32'(sh_ctl[10] && sh_ctl[5]));
    check(32'(tx_res_insert), 32'(sh_ctl[10] && un));
    if (sh_ctl[10]) begin
      check(32'(tx_res_rate_bytes), 32'(rbytes(len)));
    end
  endtask

  task automatic t_reset;
    logic [31:0] rd;
    logic e;
    rd_chk(`SPCR_ADDR_CTRL_B, 32'h00000607, 1'b0);
    rd_chk(`SPCR_ADDR_TAG, 32'h00000001, 1'b0);
    rd_chk(`SPCR_ADDR_RATE, 32'h00000000, 1'b0);
    port_chk;
    rd_chk(12'h01C, 32'h00000000, 1'b1);
    apb(1'b1, 12'h01C, 32'h0000FFFF, rd, e);
    check(32'(e), 32'h1);
    rd_chk(`SPCR_ADDR_CTRL_B, 32'h00000607, 1'b0);
  endtask

  task automatic t_regs;
    wr(`SPCR_ADDR_CTRL_B, 16'hFFFF);
    rd_chk(`SPCR_ADDR_CTRL_B, 32'h00007FEF, 1'b0);
    port_chk;
    wr(`SPCR_ADDR_CTRL_B, 16'h0000);
    an_pause <= 1'b1;
    port_chk;
    @(posedge mclk);
    an_pause <= 1'b0;
    port_chk;
    wr(`SPCR_ADDR_TAG, 16'hFFFF);
    rd_chk(`SPCR_ADDR_TAG, 32'h0000FFFF, 1'b0);
    // lane 0 only: the upper byte keeps its value; the tag shadow is rewritten before use
    pstrb <= 4'h1;
    wr(`SPCR_ADDR_TAG, 16'h0000);
    rd_chk(`SPCR_ADDR_TAG, 32'h0000FF00, 1'b0);
    pstrb <= 4'hF;
    wr(`SPCR_ADDR_RATE, 16'hFFFF);
    rd_chk(`SPCR_ADDR_RATE, 32'h0000000F, 1'b0);
  endtask

  task automatic t_ingress;
    logic [15:0] cfg [6] = '{16'h0607, 16'h4607, 16'h2607, 16'h0407, 16'h0747, 16'h060F};
    wr(`SPCR_ADDR_RATE, 16'h0000);
    wr(`SPCR_ADDR_TAG, 16'hA005);
    foreach (cfg[i]) begin
      wr(`SPCR_ADDR_CTRL_B, cfg[i]);
      rx_chk(1'b0, 12'h123, 3'h7, 3'h1, 3'h0, 11'h040);
      rx_chk(1'b1, 12'h005, 3'h7, 3'h1, 3'h0, 11'h040);
      rx_chk(1'b1, 12'h009, 3'h2, 3'h6, 3'h0, 11'h040);
      rx_chk(1'b1, 12'h000, 3'h6, 3'h1, 3'h0, 11'h040);
    end
  endtask

  // every mode with every gap and preamble combination, one frame of each class
  task automatic t_limit;
    wr(`SPCR_ADDR_CTRL_B, 16'h0607);
    for (int m = 0; m < 16; m++) begin
      wr(`SPCR_ADDR_RATE, 16'(m));
      rx_chk(1'b0, 12'h000, 3'h0, 3'h1, 3'h4, 11'h7FF);
      rx_chk(1'b0, 12'h000, 3'h0, 3'h1, 3'h2, 11'h040);
      rx_chk(1'b0, 12'h000, 3'h0, 3'h1, 3'h1, 11'h000);
      rx_chk(1'b0, 12'h000, 3'h0, 3'h1, 3'h0, 11'h200);
    end
  endtask

  task automatic t_egress;
    logic [15:0] cfg [3] = '{16'h0627, 16'h0207, 16'h0607};
    wr(`SPCR_ADDR_TAG, 16'h3ABC);
    wr(`SPCR_ADDR_RATE, 16'h0003);
    foreach (cfg[i]) begin
      wr(`SPCR_ADDR_CTRL_B, cfg[i]);
      tx_chk(1'b1, 11'h7FF);
      tx_chk(1'b0, 11'h040);
    end
  endtask

  // with the clock enable low a presented frame must leave no result behind
  task automatic t_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    rx_frm_valid <= 1'b1;
    tx_frm_valid <= 1'b1;
    @(posedge mclk);
    rx_frm_valid <= 1'b0;
    tx_frm_valid <= 1'b0;
    ce <= 1'b1;
    @(negedge mclk);
    check(32'(rx_res_valid), 32'h0);
    check(32'(tx_res_valid), 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_ingress;
    t_limit;
    t_egress;
    t_freeze;
    end_of_test;
  end

  // the whole run needs well under 2000 cycles
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
endmodule
